// ===== logic/sfs_front_end.sv
// Serial flash front end: link side on the serial clock, command side on clk.
// Assumes a memory core that answers read fetches and runs launched operations.
`timescale 1ns/1ns
`include "sfs_params.svh"

// Behaviour
// - Works with serial clock idling low or high; only edges matter.
// - Select low starts a frame; select high ends and resets it.
// - Deselected: standby, serial output floated.
// - Deselected: serial input ignored, nothing captured.
// - Standby waits until a launched program or erase has finished.
// - Command, address and write data sampled on rising serial clock.
// - Output data changes only on falling serial clock.
// - Dual read drives two bits per falling edge, input pin turned output.
// - Dual program samples two bits per rising edge, output pin as input.
// - Write-protect idles high; low freezes protected sectors.
// - Program carries 1 to 256 bytes.
// - Thirty-two 64KB sectors, each protectable on its own.
// - Erase 4KB, 32KB, 64KB aligned blocks or the whole chip.
// - 128-byte one-time register; upper half writable once.
// - Locked sectors reject every later program or erase.
// - Global protect sets all sectors at once; global unprotect clears all but locked ones.
// - Hold ignores clock and input, floats output, keeps state.
module sfs_front_end #(
  parameter int SECTORS = `SFS_SECTORS
) (
  input wire logic clk, // Command side clock
  input wire logic arst_n, // Async reset, active low
  input wire logic sck, // Serial link clock
  input wire logic csN, // Chip select, active low
  input wire logic holdN, // Hold, active low
  input wire logic wpN, // Write protect, active low
  input wire logic siIn, // Serial input pin
  output logic secOutLane, // Serial input pin driven in dual read
  output logic secOutLaneOe, // Drive enable of serial input pin
  output logic soOut, // Serial output pin
  output logic soOe, // Drive enable of serial output pin
  input wire logic secInLane, // Serial output pin sampled in dual program
  output logic cmdValid, // Pulse: command and address received
  output sfs_pkg::sfs_cmd_s cmd, // Received command
  output logic wrValid, // Pulse: write data byte
  output logic [7:0] wrByte, // Write data byte
  output logic rdReq, // Pulse: fetch next read byte
  input wire logic rdAck, // Pulse: read byte valid
  input wire logic [7:0] rdByte, // Read byte from core
  output logic opValid, // Pulse: launch internal operation
  output sfs_pkg::sfs_op_s op, // Launched operation
  output logic opRejected, // Pulse: operation refused
  input wire logic opDone, // Pulse: internal operation finished
  output logic standby, // Deselected and idle
  output logic [SECTORS-1:0] sectorProt, // Protection per sector
  output logic [SECTORS-1:0] sectorLocked // Lockdown per sector
);
  import sfs_pkg::*;

  if (SECTORS != `SFS_SECTORS) begin : gChk
    $error("SECTORS must be 32");
  end

  // Link domain
  logic linkRst_n;
  logic txRst_n;
  sfs_link_e lkState_q;
  logic [4:0] bitCnt_q;
  logic [7:0] rxShift_q;
  logic [7:0] opc_q;
  logic [23:0] addrSh_q;
  logic isDual_q;
  logic [7:0] rxNext;
  logic [7:0] rxDual;
  logic cmdFire;
  logic wrFire;
  logic [7:0] wrNext;
  sfs_cmd_s cmdWordL_q;
  logic cmdTglL_q;
  logic [7:0] wrByteL_q;
  logic wrTglL_q;
  logic [7:0] txShift_q;
  logic [1:0] txCnt_q;
  logic [2:0] txCntS_q;
  logic [7:0] txCur;
  logic txLoad;
  logic fetchTglL_q;
  logic [7:0] rdBuf_q;

  assign linkRst_n = ~csN;
  assign txRst_n = ~csN & holdN;
  assign rxNext = {rxShift_q[6:0], siIn};
  assign rxDual = {rxShift_q[5:0], secInLane, siIn};

  function automatic logic hasAddr(input logic [7:0] o);
    hasAddr = !(o == `SFS_OPC_CHIP || o == `SFS_OPC_GPROT || o == `SFS_OPC_GUNPROT);
  endfunction

  function automatic logic isRead(input logic [7:0] o);
    isRead = (o == `SFS_OPC_READ || o == `SFS_OPC_DREAD || o == `SFS_OPC_OTPREAD);
  endfunction

  function automatic logic isProg(input logic [7:0] o);
    isProg = (o == `SFS_OPC_PROG || o == `SFS_OPC_DPROG || o == `SFS_OPC_OTPPROG);
  endfunction

  always_comb begin
    cmdFire = 1'b0;
    wrFire = 1'b0;
    wrNext = rxNext;
    if (holdN) begin
      case (lkState_q)
        LK_OPC: cmdFire = (bitCnt_q == 5'h07) && !hasAddr(rxNext);
        LK_ADDR: cmdFire = (bitCnt_q == `SFS_ADDR_LAST);
        LK_WR: begin
          if (isDual_q) begin
            wrFire = (bitCnt_q == 5'h06);
            wrNext = rxDual;
          end else begin
            wrFire = (bitCnt_q == 5'h07);
          end
        end
        default: ;
      endcase
    end
  end

  // Frame state; select high holds it in reset
  always_ff @(posedge sck or negedge linkRst_n) begin
    if (!linkRst_n) begin
      lkState_q <= LK_OPC;
      bitCnt_q <= 5'h00;
      rxShift_q <= 8'h00;
      opc_q <= 8'h00;
      addrSh_q <= 24'h000000;
      isDual_q <= 1'b0;
    end else if (holdN) begin
      case (lkState_q)
        LK_OPC: begin
          rxShift_q <= rxNext;
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == 5'h07) begin
            opc_q <= rxNext;
            bitCnt_q <= 5'h00;
            isDual_q <= (rxNext == `SFS_OPC_DREAD) || (rxNext == `SFS_OPC_DPROG);
            lkState_q <= hasAddr(rxNext) ? LK_ADDR : LK_IDLE;
          end
        end
        LK_ADDR: begin
          addrSh_q <= {addrSh_q[22:0], siIn};
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == `SFS_ADDR_LAST) begin
            bitCnt_q <= 5'h00;
            if (isRead(opc_q)) begin
              lkState_q <= LK_DUMMY;
            end else if (isProg(opc_q)) begin
              lkState_q <= LK_WR;
            end else begin
              lkState_q <= LK_IDLE;
            end
          end
        end
        LK_DUMMY: begin
          bitCnt_q <= bitCnt_q + 5'h01;
          if (bitCnt_q == `SFS_DUMMY_LAST) begin
            lkState_q <= LK_RD;
          end
        end
        LK_WR: begin
          if (isDual_q) begin
            rxShift_q <= rxDual;
            bitCnt_q <= wrFire ? 5'h00 : bitCnt_q + 5'h02;
          end else begin
            rxShift_q <= rxNext;
            bitCnt_q <= wrFire ? 5'h00 : bitCnt_q + 5'h01;
          end
        end
        default: ;
      endcase
    end
  end

  // Crossing words; held stable until the next toggle
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      cmdWordL_q <= '0;
      cmdTglL_q <= 1'b0;
    end else if (cmdFire) begin
      cmdWordL_q.opcode <= (lkState_q == LK_OPC) ? rxNext : opc_q;
      cmdWordL_q.addr <= (lkState_q == LK_OPC) ? 24'h000000 : {addrSh_q[22:0], siIn};
      cmdTglL_q <= ~cmdTglL_q;
    end
  end

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      wrByteL_q <= 8'h00;
      wrTglL_q <= 1'b0;
    end else if (wrFire) begin
      wrByteL_q <= wrNext;
      wrTglL_q <= ~wrTglL_q;
    end
  end

  // Read shifter on falling edges
  assign txLoad = isDual_q ? (txCnt_q == 2'h0) : (txCntS_q == 3'h0);
  assign txCur = txLoad ? rdBuf_q : txShift_q;

  always_ff @(negedge sck or negedge linkRst_n) begin
    if (!linkRst_n) begin
      txShift_q <= 8'h00;
      txCnt_q <= 2'h0;
      txCntS_q <= 3'h0;
    end else if (holdN && lkState_q == LK_RD) begin
      if (isDual_q) begin
        txShift_q <= {txCur[5:0], 2'b00};
        txCnt_q <= txCnt_q - 2'h1;
      end else begin
        txShift_q <= {txCur[6:0], 1'b0};
        txCntS_q <= txCntS_q - 3'h1;
      end
    end
  end

  always_ff @(negedge sck or negedge arst_n) begin
    if (!arst_n) begin
      fetchTglL_q <= 1'b0;
    end else if (holdN && lkState_q == LK_RD && !csN && txLoad) begin
      fetchTglL_q <= ~fetchTglL_q;
    end
  end

  // Pin drivers float on deselect or hold
  always_ff @(negedge sck or negedge txRst_n) begin
    if (!txRst_n) begin
      soOut <= 1'b0;
      soOe <= 1'b0;
      secOutLane <= 1'b0;
      secOutLaneOe <= 1'b0;
    end else if (lkState_q == LK_RD) begin
      soOut <= txCur[7];
      soOe <= 1'b1;
      secOutLane <= txCur[6];
      secOutLaneOe <= isDual_q;
    end
  end

  AST_DUAL_OUT: assert property (@(negedge sck) disable iff (csN)
    secOutLaneOe |-> isDual_q && lkState_q == LK_RD && soOe)
    else $error("second lane driven outside dual read");

  // Command domain
  logic [4:0] syncIn;
  logic [4:0] syncOut;
  logic csS;
  logic wpS;
  logic csDly_q;
  logic cmdTglD_q;
  logic wrTglD_q;
  logic fetchTglD_q;
  logic cmdEv;
  logic wrEv;
  logic fetchEv;
  logic endPend_q;
  logic cmdHas_q;
  logic [8:0] dataCnt_q;
  logic busy_q;
  logic otpUsed_q;
  logic actEn;
  logic want;
  logic blocked;
  logic launch;
  sfs_op_e kind;
  logic [23:0] opAddr;
  logic [4:0] sect;

  assign syncIn = {cmdTglL_q, wrTglL_q, fetchTglL_q, wpN, csN};

  sfs_sync #(.W(5), .RST_VAL(5'b00011)) uSync (
    .clk(clk),
    .arst_n(arst_n),
    .async(syncIn),
    .sync(syncOut)
  );

  assign csS = syncOut[0];
  assign wpS = syncOut[1];
  assign cmdEv = syncOut[4] ^ cmdTglD_q;
  assign wrEv = syncOut[3] ^ wrTglD_q;
  assign fetchEv = syncOut[2] ^ fetchTglD_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      csDly_q <= 1'b1;
      cmdTglD_q <= 1'b0;
      wrTglD_q <= 1'b0;
      fetchTglD_q <= 1'b0;
      endPend_q <= 1'b0;
    end else begin
      csDly_q <= csS;
      cmdTglD_q <= syncOut[4];
      wrTglD_q <= syncOut[3];
      fetchTglD_q <= syncOut[2];
      endPend_q <= csS & ~csDly_q;
    end
  end

  // Command, data and read fetch hand-off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= '0;
      cmdValid <= 1'b0;
      cmdHas_q <= 1'b0;
      dataCnt_q <= 9'h000;
      wrValid <= 1'b0;
      wrByte <= 8'h00;
      rdReq <= 1'b0;
      rdBuf_q <= 8'h00;
    end else begin
      cmdValid <= cmdEv;
      wrValid <= wrEv;
      rdReq <= fetchEv || (cmdEv && isRead(cmdWordL_q.opcode));
      if (cmdEv) begin
        cmd <= cmdWordL_q;
        cmdHas_q <= 1'b1;
        dataCnt_q <= 9'h000;
      end else if (endPend_q) begin
        cmdHas_q <= 1'b0;
      end
      if (wrEv) begin
        wrByte <= wrByteL_q;
        if (dataCnt_q != `SFS_PAGE_BYTES) begin
          dataCnt_q <= dataCnt_q + 9'h001;
        end
      end
      if (rdAck) begin
        rdBuf_q <= rdByte;
      end
    end
  end

  // Frame end decides launch or refusal
  assign actEn = endPend_q && cmdHas_q;
  assign sect = cmd.addr[`SFS_SECT_LSB+4:`SFS_SECT_LSB];

  always_comb begin
    want = 1'b0;
    blocked = sectorProt[sect] | sectorLocked[sect];
    kind = OP_PROG;
    opAddr = cmd.addr;
    case (cmd.opcode)
      `SFS_OPC_PROG, `SFS_OPC_DPROG: want = (dataCnt_q != 9'h000);
      `SFS_OPC_OTPPROG: begin
        want = (dataCnt_q != 9'h000);
        kind = OP_OTP;
        blocked = otpUsed_q | ~cmd.addr[`SFS_OTP_USER_BIT];
      end
      `SFS_OPC_ER4: begin
        want = 1'b1;
        kind = OP_ERASE4;
        opAddr = cmd.addr & `SFS_BLK4_MASK;
      end
      `SFS_OPC_ER32: begin
        want = 1'b1;
        kind = OP_ERASE32;
        opAddr = cmd.addr & `SFS_BLK32_MASK;
      end
      `SFS_OPC_ER64: begin
        want = 1'b1;
        kind = OP_ERASE64;
        opAddr = cmd.addr & `SFS_BLK64_MASK;
      end
      `SFS_OPC_CHIP: begin
        want = 1'b1;
        kind = OP_CHIP;
        opAddr = 24'h000000;
        blocked = (|sectorProt) | (|sectorLocked);
      end
      default: ;
    endcase
  end

  assign launch = actEn && want && !blocked && !busy_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opValid <= 1'b0;
      op <= '0;
      opRejected <= 1'b0;
      otpUsed_q <= 1'b0;
    end else begin
      opValid <= launch;
      opRejected <= actEn && want && (blocked || busy_q);
      if (launch) begin
        op.kind <= kind;
        op.addr <= opAddr;
        op.len <= dataCnt_q;
        if (kind == OP_OTP) begin
          otpUsed_q <= 1'b1;
        end
      end
    end
  end

  // Busy spans the internal cycle; a new launch wins over done
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
      standby <= 1'b1;
    end else begin
      if (launch) begin
        busy_q <= 1'b1;
      end else if (opDone) begin
        busy_q <= 1'b0;
      end
      standby <= csS && !busy_q && !launch;
    end
  end

  // Sector protection and lockdown
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sectorProt <= `SFS_PROT_RESET;
      sectorLocked <= '0;
    end else if (actEn) begin
      case (cmd.opcode)
        `SFS_OPC_PROT: sectorProt[sect] <= 1'b1;
        `SFS_OPC_UNPROT: begin
          if (wpS && !sectorLocked[sect]) begin
            sectorProt[sect] <= 1'b0;
          end
        end
        `SFS_OPC_GPROT: sectorProt <= '1;
        `SFS_OPC_GUNPROT: begin
          if (wpS) begin
            sectorProt <= sectorLocked;
          end
        end
        `SFS_OPC_LOCK: begin
          sectorLocked[sect] <= 1'b1;
          sectorProt[sect] <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  AST_DESEL_FLOAT: assert property (@(posedge clk) disable iff (!arst_n)
    csS && csDly_q |-> !soOe && !secOutLaneOe)
    else $error("output driven while deselected");

  AST_STANDBY_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
    busy_q |-> !standby)
    else $error("standby during internal operation");

  AST_PROG_LEN: assert property (@(posedge clk) disable iff (!arst_n)
    opValid && op.kind == OP_PROG |-> op.len >= 9'h001 && op.len <= 9'h100)
    else $error("program length out of range");

  AST_ERASE_ALIGN: assert property (@(posedge clk) disable iff (!arst_n)
    opValid && op.kind == OP_ERASE32 |-> op.addr[14:0] == 15'h0000)
    else $error("32KB erase not aligned");

  AST_LOCK_HOLDS: assert property (@(posedge clk) disable iff (!arst_n)
    opValid && op.kind != OP_OTP && op.kind != OP_CHIP
      |-> !sectorLocked[op.addr[20:16]] && !sectorProt[op.addr[20:16]])
    else $error("operation launched on locked sector");

  AST_OTP_ONCE: assert property (@(posedge clk) disable iff (!arst_n)
    opValid && op.kind == OP_OTP |-> !$past(otpUsed_q) && op.addr[6] && otpUsed_q)
    else $error("one-time register written twice");

  AST_GLOBAL_PROT: assert property (@(posedge clk) disable iff (!arst_n)
    actEn && cmd.opcode == `SFS_OPC_GPROT |=> sectorProt == '1 ##1 opValid == 1'b0)
    else $error("global protect incomplete");

  AST_WP_HOLDS: assert property (@(posedge clk) disable iff (!arst_n)
    actEn && !wpS && cmd.opcode == `SFS_OPC_GUNPROT |=> $stable(sectorProt))
    else $error("unprotect while write protect low");
endmodule

// ===== logic/sfs_params.svh
// Constants of the serial flash front end: opcodes, counts, masks.
// Assumes inclusion by bare name from the design files.
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH
`define SFS_OPC_PROG 8'h02
`define SFS_OPC_DPROG 8'ha2
`define SFS_OPC_READ 8'h0b
`define SFS_OPC_DREAD 8'h3b
`define SFS_OPC_OTPREAD 8'h77
`define SFS_OPC_OTPPROG 8'h9b
`define SFS_OPC_ER4 8'h20
`define SFS_OPC_ER32 8'h52
`define SFS_OPC_ER64 8'hd8
`define SFS_OPC_CHIP 8'h60
`define SFS_OPC_PROT 8'h36
`define SFS_OPC_UNPROT 8'h39
`define SFS_OPC_GPROT 8'h7e
`define SFS_OPC_GUNPROT 8'h98
`define SFS_OPC_LOCK 8'h33
`define SFS_ADDR_LAST 5'h17
`define SFS_DUMMY_LAST 5'h07
`define SFS_SECT_LSB 16
`define SFS_SECTORS 32
`define SFS_PAGE_BYTES 9'h100
`define SFS_OTP_USER_BIT 6
`define SFS_PROT_RESET 32'hffffffff
`define SFS_BLK4_MASK 24'hfff000
`define SFS_BLK32_MASK 24'hff8000
`define SFS_BLK64_MASK 24'hff0000
`endif

// ===== logic/sfs_pkg.sv
// Types shared by the serial flash front end.
// Assumes nothing beyond a SystemVerilog compiler.
package sfs_pkg;
  typedef enum logic [2:0] {
    OP_PROG, OP_ERASE4, OP_ERASE32, OP_ERASE64, OP_CHIP, OP_OTP
  } sfs_op_e;
  typedef enum logic [2:0] {
    LK_OPC, LK_ADDR, LK_DUMMY, LK_RD, LK_WR, LK_IDLE
  } sfs_link_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
  } sfs_cmd_s;
  typedef struct packed {
    sfs_op_e kind;
    logic [23:0] addr;
    logic [8:0] len;
  } sfs_op_s;
endpackage

// ===== logic/sfs_sync.sv
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a level or toggle from another domain.
`timescale 1ns/1ns
module sfs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // Destination clock
  input wire logic arst_n, // Async reset, active low
  input wire logic [W-1:0] async, // Foreign levels
  output logic [W-1:0] sync // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
    end else begin
      meta_q <= async;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync <= RST_VAL;
    end else begin
      sync <= meta_q;
    end
  end
endmodule

// ===== verif/sfs_host_model.sv
// SPI host model: drives select, clock, hold and the host side of both data lanes.
// Assumes the bench resolves each two-way pin from the device drive enables.
`timescale 1ns/1ns
module sfs_host_model (
  output logic csN, // Select, active low
  output logic sck, // Serial clock, 160 ns
  output logic holdN, // Hold, active low
  output logic siDrv, // Host value on serial input pin
  output logic soDrv, // Host value on serial output pin
  input wire logic siPin, // Resolved serial input pin
  input wire logic soPin // Resolved serial output pin
);
  logic cpol;
  logic [7:0] rx;
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    holdN = 1'b1;
    siDrv = 1'b0;
    soDrv = 1'b0;
    cpol = 1'b0;
    rx = 8'h00;
  end
  // Idle level picks clock mode 0 or 3
  task automatic open(input logic p);
    cpol = p;
    sck = p;
    #80 csN = 1'b0;
    #80;
  endtask
  // m: 0 single in, 1 dual in, 2 single out, 3 dual out; released lanes toggle
  task automatic tick(input logic hi, input logic lo, input int m);
    sck = 1'b0;
    case (m)
      0: begin
        siDrv = hi;
        soDrv = ~soDrv;
      end
      1: begin
        soDrv = hi;
        siDrv = lo;
      end
      default: begin
        siDrv = ~siDrv;
        soDrv = ~soDrv;
      end
    endcase
    #80 sck = 1'b1;
    rx = (m == 3) ? {rx[5:0], soPin, siPin} : {rx[6:0], soPin};
    #80;
  endtask
  task automatic put(input logic [31:0] v, input int n, input int m);
    for (int i = n - 1; i >= 0; i = i - ((m == 1) ? 2 : 1)) begin
      tick(v[i], v[(i > 0) ? i - 1 : 0], m);
    end
  endtask
  task automatic get(input int m, output logic [7:0] b);
    repeat ((m == 3) ? 4 : 8) tick(1'b0, 1'b0, m);
    b = rx;
  endtask
  // Junk clocks under hold, entered and left with the clock low
  task automatic pause();
    sck = 1'b0;
    #40 holdN = 1'b0;
    repeat (4) tick(1'b1, 1'b0, 0);
    sck = 1'b0;
    #40 holdN = 1'b1;
  endtask
  task automatic close();
    sck = cpol;
    #80 csN = 1'b1;
    #1000;
  endtask
endmodule

// ===== verif/tb.sv
// Testbench of the serial flash front end with a host model and a small core model.
// Assumes launches and protection updates settle within ten clk of select rising.
`timescale 1ns/1ns
module tb;
  import sfs_pkg::*;
  logic clk, arst_n, wpN, rdAck, opDone, csN, sck, holdN, siDrv, soDrv, siPin, soPin;
  logic secOutLane, secOutLaneOe, soOut, soOe, cmdValid, wrValid, rdReq, opValid;
  logic opRejected, standby;
  logic [7:0] rdByte, wrByte, lastWr, got;
  logic [31:0] sectorProt, sectorLocked;
  logic [4:0] busyCnt = 5'd0;
  sfs_cmd_s cmd, lastCmd;
  sfs_op_s op, lastOp;
  int nCmd = 0, nWr = 0, nOp = 0, nRej = 0, n_fail = 0, n_tests = 0, n0, w0;
  assign siPin = secOutLaneOe ? secOutLane : siDrv;
  assign soPin = soOe ? soOut : soDrv;
  sfs_host_model host (.csN(csN), .sck(sck), .holdN(holdN), .siDrv(siDrv), .soDrv(soDrv),
    .siPin(siPin), .soPin(soPin));
  sfs_front_end DUT (.clk(clk), .arst_n(arst_n), .sck(sck), .csN(csN), .holdN(holdN),
    .wpN(wpN), .siIn(siPin), .secOutLane(secOutLane), .secOutLaneOe(secOutLaneOe),
    .soOut(soOut), .soOe(soOe), .secInLane(soPin), .cmdValid(cmdValid), .cmd(cmd),
    .wrValid(wrValid), .wrByte(wrByte), .rdReq(rdReq), .rdAck(rdAck), .rdByte(rdByte),
    .opValid(opValid), .op(op), .opRejected(opRejected), .opDone(opDone),
    .standby(standby), .sectorProt(sectorProt), .sectorLocked(sectorLocked));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Core: read byte one clk after each request, operations finish after 20 clk
  always @(posedge clk) begin
    rdAck <= rdReq;
    opDone <= (busyCnt == 5'd1);
    busyCnt <= opValid ? 5'd20 : (busyCnt != 5'd0) ? busyCnt - 5'd1 : 5'd0;
  end
  always @(posedge clk) begin
    if (cmdValid) begin
      nCmd++;
      lastCmd = cmd;
    end
    if (wrValid) begin
      nWr++;
      lastWr = wrByte;
    end
    if (opValid) begin
      nOp++;
      lastOp = op;
    end
    if (opRejected) nRej++;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic await_op(input int n);
    int k;
    k = 0;
    while (nOp + nRej == n && k < 80) begin
      @(negedge clk);
      k++;
    end
    if (nOp + nRej == n) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic await_idle();
    int k;
    k = 0;
    while (standby !== 1'b1 && k < 80) begin
      @(negedge clk);
      k++;
    end
    if (standby !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic cmdf(input logic p, input logic [7:0] opc, input bit hasA,
      input logic [23:0] adr);
    host.open(p);
    host.put({24'h0, opc}, 8, 0);
    if (hasA) host.put({8'h0, adr}, 24, 0);
  endtask
  task automatic s_reset();
    chk({standby, soOe, secOutLaneOe}, 3'b100);
    chk(sectorProt, 32'hffffffff);
    chk(sectorLocked, 32'h0);
  endtask
  task automatic s_deselect();
    n0 = nCmd;
    host.put(32'h00000b00, 16, 0);
    repeat (10) @(negedge clk);
    chk(nCmd, n0);
    chk({standby, soOe}, 2'b10);
  endtask
  task automatic s_wp();
    @(posedge clk) wpN <= 1'b0;
    cmdf(1'b0, 8'h98, 0, 24'h0);
    host.close();
    chk(sectorProt, 32'hffffffff);
    @(posedge clk) wpN <= 1'b1;
    cmdf(1'b1, 8'h98, 0, 24'h0);
    host.close();
    chk(sectorProt, 32'h0);
  endtask
  task automatic s_erase();
    logic [7:0] opcs [4] = '{8'h20, 8'h52, 8'hd8, 8'h60};
    sfs_op_e kinds [4] = '{OP_ERASE4, OP_ERASE32, OP_ERASE64, OP_CHIP};
    logic [23:0] masks [3] = '{24'hfff000, 24'hff8000, 24'hff0000};
    for (int i = 0; i < 4; i++) begin
      n0 = nOp + nRej;
      cmdf(i[0], opcs[i], i < 3, 24'h1a5b3c);
      host.close();
      await_op(n0);
      chk(lastCmd.opcode, opcs[i]);
      chk(lastOp.kind, kinds[i]);
      if (i < 3) chk(lastOp.addr, 24'h1a5b3c & masks[i]);
      chk(standby, 1'b0);
      await_idle();
    end
  endtask
  task automatic s_prog();
    int cnt [3] = '{1, 256, 2};
    for (int i = 0; i < 3; i++) begin
      n0 = nOp + nRej;
      w0 = nWr;
      cmdf(1'b0, (i == 2) ? 8'ha2 : 8'h02, 1, 24'h0a0000);
      for (int j = 0; j < cnt[i]; j++) host.put({24'h0, 8'h5a ^ j[7:0]}, 8, (i == 2) ? 1 : 0);
      host.close();
      await_op(n0);
      chk(nWr - w0, cnt[i]);
      chk(lastWr, 8'h5a ^ (cnt[i] - 1));
      chk({lastOp.kind, lastOp.len}, {OP_PROG, cnt[i][8:0]});
      await_idle();
    end
  endtask
  task automatic s_read();
    for (int i = 0; i < 2; i++) begin
      cmdf(i[0], (i == 1) ? 8'h3b : 8'h0b, 1, 24'h000040);
      host.put(32'h0, 8, 0);
      repeat (2) begin
        host.get((i == 1) ? 3 : 2, got);
        chk(got, 8'hb4);
      end
      chk({soOe, secOutLaneOe}, (i == 1) ? 2'b11 : 2'b10);
      host.close();
      chk({soOe, secOutLaneOe}, 2'b00);
    end
  endtask
  task automatic s_hold();
    n0 = nOp + nRej;
    host.open(1'b0);
    host.put(32'h20, 8, 0);
    host.put(32'h0b7, 12, 0);
    host.pause();
    host.put(32'h123, 12, 0);
    host.close();
    await_op(n0);
    chk({lastOp.kind, lastOp.addr}, {OP_ERASE4, 24'h0b7000});
    await_idle();
  endtask
  // One-time register: lower half refused, upper half once only
  task automatic s_otp();
    logic [23:0] adr [3] = '{24'h000000, 24'h000040, 24'h000041};
    for (int i = 0; i < 3; i++) begin
      n0 = nOp;
      w0 = nRej;
      cmdf(1'b0, 8'h9b, 1, adr[i]);
      host.put(32'h3c, 8, 0);
      host.close();
      chk(nOp - n0, i == 1);
      chk(nRej - w0, i != 1);
      await_idle();
    end
    chk({lastOp.kind, lastOp.addr}, {OP_OTP, 24'h000040});
  endtask
  task automatic s_lock();
    cmdf(1'b0, 8'h33, 1, 24'h050000);
    host.close();
    chk(sectorLocked, 32'h00000020);
    cmdf(1'b0, 8'h36, 1, 24'h070000);
    host.close();
    chk(sectorProt, 32'h000000a0);
    cmdf(1'b0, 8'h98, 0, 24'h0);
    host.close();
    chk(sectorProt, 32'h00000020);
    n0 = nOp + nRej;
    w0 = nRej;
    cmdf(1'b0, 8'h20, 1, 24'h051000);
    host.close();
    await_op(n0);
    chk(nRej - w0, 1);
    cmdf(1'b1, 8'h7e, 0, 24'h0);
    host.close();
    chk(sectorProt, 32'hffffffff);
    cmdf(1'b0, 8'h39, 1, 24'h070000);
    host.close();
    cmdf(1'b1, 8'h39, 1, 24'h050000);
    host.close();
    chk(sectorProt, 32'hffffff7f);
  endtask
  initial begin
    arst_n = 1'b0;
    wpN = 1'b1;
    rdByte = 8'hb4;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    s_reset();
    s_deselect();
    s_wp();
    s_erase();
    s_prog();
    s_read();
    s_hold();
    s_otp();
    s_lock();
    // Second reset in mid-run clears lockdown and restores protection
    @(posedge clk) arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    s_reset();
    close_out();
  end
endmodule
